// ==== inc/nvbs_regs.vh ====
`ifndef NVBS_REGS_VH
`define NVBS_REGS_VH

// Array and entry geometry
`define NVBS_ARRAY_SIZE    8'h64
`define NVBS_PAGE_AW       9
`define NVBS_ENTRY_W       24
`define NVBS_LAST_SLOT     9'h1FF
`define NVBS_ERASED_ADDR   8'hFF
`define NVBS_ILLEGAL_DATA  8'hFF
`define NVBS_CHECK_KEY     8'h5A
`define NVBS_PAGE_TAG      24'h00A5C3
`define NVBS_MAINT_PERIOD  8'hC8

// Status byte fields and reset values
`define NVBS_WSTAT_RESET   8'h00
`define NVBS_RSTAT_RESET   8'h00
`define NVBS_WR_ERR_BIT    0
`define NVBS_ILL_ADDR_BIT  1
`define NVBS_FLASH_BIT     2
`define NVBS_CORRUPT_BIT   4

// Timing, figures in ns (maintenance limit in ms) at the system clock in MHz
`define NVBS_CLK_MHZ       250
`define NVBS_WRITE_NS      136000
`define NVBS_ILL_WRITE_NS  7000
`define NVBS_ILL_READ_NS   6000
`define NVBS_READ_MIN_NS   71000
`define NVBS_READ_MAX_NS   258000
`define NVBS_READ_STEP_NS  800
`define NVBS_MAINT_MAX_MS  58
`define NVBS_CYC_UP(ns)    (((ns) * `NVBS_CLK_MHZ + 999) / 1000)
`define NVBS_CYC_DN(ns)    (((ns) * `NVBS_CLK_MHZ) / 1000)

`endif

// ==== verilog/nvbs_flash.v ====
`timescale 1ns/10ps
`default_nettype none
`include "nvbs_regs.vh"

// Two-page flash array: program can only clear bits, erase sets a page to ones
module nvbs_flash #(
   parameter AW = 10,
   parameter DW = `NVBS_ENTRY_W
) (
   input  wire          clk,
   input  wire [AW-1:0] rd_idx,
   output wire [DW-1:0] rd_entry,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_idx,
   input  wire [DW-1:0] wr_entry,
   input  wire          erase_en,
   input  wire          erase_page
);

   localparam PAGE_N = 1 << (AW - 1);

   reg [DW-1:0] mem [0:(1<<AW)-1];
   integer      i;

   // Blank part as shipped
   initial begin
      for (i = 0; i < (1 << AW); i = i + 1) begin
         mem[i] = {DW{1'b1}};
      end
   end

   assign rd_entry = mem[rd_idx];

   always @(posedge clk) begin
      if (erase_en) begin
         for (i = 0; i < PAGE_N; i = i + 1) begin
            mem[{erase_page, i[AW-2:0]}] <= {DW{1'b1}};
         end
      end else if (wr_en) begin
         mem[wr_idx] <= mem[wr_idx] & wr_entry;
      end
   end

endmodule
`default_nettype wire

// ==== verilog/nvbs_top.v ====
// Notes on behaviour
// RULE1 - Store holds 100 bytes, each with a one-byte address and value.
// RULE2 - Writes append to a log so placement moves and wear spreads.
// RULE3 - Caller gives address then data and starts the write entry.
// RULE4 - Write return leaves the write status in the first working register.
// RULE5 - Caller gives the address and starts the read entry.
// RULE6 - Read return gives data in first, status in second working register.
// RULE7 - Caller keeps 16 bytes of spare stack for either routine.
// RULE8 - Caller working registers are untouched until the result is placed.
// RULE9 - Interrupts stay on; interrupt code must not disturb the call.
// RULE10 - Caller sets flash timing to match the system clock first.
// RULE11 - A normal write takes about 136 us at a 20 MHz clock.
// RULE12 - Every 200 writes a maintenance erase runs; up to 58 ms.
// RULE13 - Write past array size changes nothing, takes 7 us, flags address.
// RULE14 - Each write is read back; mismatch sets write error bit 0.
// RULE15 - Write status: flash fault bit 2, address bit 1, others zero.
// RULE16 - Read past array size returns FF in 6 us, flags address bit 1.
// RULE17 - Read status zero on success; corruption returns last good value.
// RULE18 - Read status: corrupt bit 4, flash fault bit 2, others zero.
// RULE19 - A read takes between 71 and 258 us at 20 MHz.
// RULE20 - Unwritten reads slow 0.8 us per write since erase, capped.
// RULE21 - Power loss endangers only the byte in flight with brownout on.
// RULE22 - Reset mid-write may corrupt only the byte being written.
// RULE23 - Done is given only after all work and status placement.
`timescale 1ns/10ps
`default_nettype none
`include "nvbs_regs.vh"

module nvbs_top #(
   parameter [25:0] WRITE_CYC    = `NVBS_CYC_DN(`NVBS_WRITE_NS),
   parameter [25:0] ILL_WR_CYC   = `NVBS_CYC_DN(`NVBS_ILL_WRITE_NS),
   parameter [25:0] ILL_RD_CYC   = `NVBS_CYC_DN(`NVBS_ILL_READ_NS),
   parameter [25:0] READ_MIN_CYC = `NVBS_CYC_UP(`NVBS_READ_MIN_NS),
   parameter [25:0] READ_MAX_CYC = `NVBS_CYC_DN(`NVBS_READ_MAX_NS),
   parameter [9:0]  READ_STEP    = `NVBS_CYC_DN(`NVBS_READ_STEP_NS)
) (
   input  wire       clk,
   input  wire       rstn,
   input  wire       call_write,
   input  wire       call_read,
   input  wire [7:0] call_addr,
   input  wire [7:0] call_data,
   input  wire       brownout_monitor,
   output reg        busy_reg,
   output reg        done_reg,
   output reg  [7:0] first_working_register,
   output reg  [7:0] second_working_register
);

   localparam [3:0] S_INIT0  = 4'h0;
   localparam [3:0] S_INIT1  = 4'h1;
   localparam [3:0] S_IDLE   = 4'h2;
   localparam [3:0] S_WPROG  = 4'h3;
   localparam [3:0] S_WVER   = 4'h4;
   localparam [3:0] S_MERASE = 4'h5;
   localparam [3:0] S_MSCAN  = 4'h6;
   localparam [3:0] S_MCOPY  = 4'h7;
   localparam [3:0] S_MCVER  = 4'h8;
   localparam [3:0] S_MNEXT  = 4'h9;
   localparam [3:0] S_MTAG   = 4'hA;
   localparam [3:0] S_MOLD   = 4'hB;
   localparam [3:0] S_RSCAN  = 4'hC;
   localparam [3:0] S_WAIT   = 4'hD;

   localparam AW = `NVBS_PAGE_AW;

   reg  [3:0]    state_reg;
   reg           act_reg;
   reg  [AW-1:0] head_reg;
   reg  [AW-1:0] idx_reg;
   reg  [AW-1:0] dh_reg;
   reg  [7:0]    wcnt_reg;
   reg  [15:0]   since_erase_reg;
   reg  [7:0]    maddr_reg;
   reg  [7:0]    addr_reg;
   reg  [7:0]    data_reg;
   reg           is_write_reg;
   reg  [7:0]    wstat_reg;
   reg  [7:0]    rstat_reg;
   reg  [7:0]    rdata_reg;
   reg  [25:0]   elapsed_reg;
   reg  [25:0]   target_reg;
   reg  [23:0]   copy_reg;

   reg           fl_wr;
   reg           fl_erase;
   reg           fl_epage;
   reg  [AW:0]   fl_idx;
   reg  [23:0]   fl_wdata;
   wire [23:0]   fl_entry;

   wire [7:0]  ent_addr  = fl_entry[23:16];
   wire [7:0]  ent_data  = fl_entry[15:8];
   wire        ent_good  = fl_entry[7:0] ==
                           (ent_addr ^ ent_data ^ `NVBS_CHECK_KEY);
   wire [23:0] new_entry = {addr_reg, data_reg,
                            addr_reg ^ data_reg ^ `NVBS_CHECK_KEY};
   wire        legal     = call_addr < `NVBS_ARRAY_SIZE;         // [RULE1]
   wire [25:0] rd_grow   = READ_MIN_CYC +
                           since_erase_reg * READ_STEP;
   wire [25:0] rd_cyc    = (rd_grow > READ_MAX_CYC) ?
                           READ_MAX_CYC : rd_grow;               // [RULE20]

   nvbs_flash #(
      .AW (AW + 1),
      .DW (`NVBS_ENTRY_W)
   ) u_flash (
      .clk        (clk),
      .rd_idx     (fl_idx),
      .rd_entry   (fl_entry),
      .wr_en      (fl_wr),
      .wr_idx     (fl_idx),
      .wr_entry   (fl_wdata),
      .erase_en   (fl_erase),
      .erase_page (fl_epage)
   );

   // Flash port steering per state
   always @* begin
      fl_wr    = 1'b0;
      fl_erase = 1'b0;
      fl_epage = act_reg;
      fl_idx   = {act_reg, idx_reg};
      fl_wdata = new_entry;
      case (state_reg)
         S_INIT0: begin
            fl_idx = {1'b0, {AW{1'b0}}};
         end
         S_WPROG: begin
            fl_wr  = 1'b1;
            fl_idx = {act_reg, head_reg};                       // [RULE2]
         end
         S_WVER: begin
            fl_idx = {act_reg, head_reg};
         end
         S_MERASE: begin
            fl_erase = 1'b1;
            fl_epage = ~act_reg;
         end
         S_MCOPY: begin
            fl_wr    = 1'b1;
            fl_idx   = {~act_reg, dh_reg};
            fl_wdata = copy_reg;
         end
         S_MCVER: begin
            fl_idx = {~act_reg, dh_reg};
         end
         S_MTAG: begin
            fl_wr    = 1'b1;
            fl_idx   = {~act_reg, {AW{1'b0}}};
            fl_wdata = `NVBS_PAGE_TAG;
         end
         S_MOLD: begin
            fl_erase = 1'b1;
         end
         default: begin
            fl_wr = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg               <= S_INIT0;
         act_reg                 <= 1'b0;
         head_reg                <= {AW{1'b0}};
         idx_reg                 <= {AW{1'b0}};
         dh_reg                  <= {AW{1'b0}};
         wcnt_reg                <= 8'h00;
         since_erase_reg         <= 16'h0000;
         maddr_reg               <= 8'h00;
         addr_reg                <= 8'h00;
         data_reg                <= 8'h00;
         is_write_reg            <= 1'b0;
         wstat_reg               <= `NVBS_WSTAT_RESET;
         rstat_reg               <= `NVBS_RSTAT_RESET;
         rdata_reg               <= 8'h00;
         elapsed_reg             <= 26'h0000000;
         target_reg              <= 26'h0000000;
         copy_reg                <= 24'h000000;
         busy_reg                <= 1'b1;
         done_reg                <= 1'b0;
         first_working_register  <= 8'h00;
         second_working_register <= 8'h00;
      end else begin
         done_reg <= 1'b0;
         if (busy_reg && elapsed_reg != 26'h3FFFFFF) begin
            elapsed_reg <= elapsed_reg + 26'h0000001;
         end
         case (state_reg)
            // Find the tagged page, then the first blank slot in it;
            // an untagged page is a copy cut short by reset   [RULE22]
            S_INIT0: begin
               act_reg   <= (fl_entry != `NVBS_PAGE_TAG);
               idx_reg   <= {{(AW-1){1'b0}}, 1'b1};
               state_reg <= S_INIT1;
            end
            S_INIT1: begin
               if (ent_addr == `NVBS_ERASED_ADDR ||
                   idx_reg == `NVBS_LAST_SLOT) begin
                  head_reg  <= idx_reg;
                  busy_reg  <= 1'b0;
                  state_reg <= S_IDLE;
               end else begin
                  idx_reg <= idx_reg + 1'b1;
               end
            end
            S_IDLE: begin
               elapsed_reg <= 26'h0000000;
               addr_reg    <= call_addr;                        // [RULE3]
               data_reg    <= call_data;
               if (call_write) begin
                  busy_reg     <= 1'b1;
                  is_write_reg <= 1'b1;
                  wstat_reg    <= `NVBS_WSTAT_RESET;            // [RULE15]
                  if (!legal) begin
                     wstat_reg[`NVBS_ILL_ADDR_BIT] <= 1'b1;      // [RULE13]
                     target_reg <= ILL_WR_CYC;
                     state_reg  <= S_WAIT;
                  end else if (!brownout_monitor ||
                               head_reg == `NVBS_LAST_SLOT) begin
                     wstat_reg[`NVBS_FLASH_BIT] <= 1'b1;         // [RULE21]
                     target_reg <= WRITE_CYC;
                     state_reg  <= S_WAIT;
                  end else begin
                     target_reg <= WRITE_CYC;                    // [RULE11]
                     state_reg  <= S_WPROG;
                  end
               end else if (call_read) begin
                  busy_reg     <= 1'b1;
                  is_write_reg <= 1'b0;
                  rstat_reg    <= `NVBS_RSTAT_RESET;             // [RULE18]
                  if (!legal) begin
                     rdata_reg <= `NVBS_ILLEGAL_DATA;            // [RULE16]
                     rstat_reg[`NVBS_ILL_ADDR_BIT] <= 1'b1;
                     target_reg <= ILL_RD_CYC;
                     state_reg  <= S_WAIT;
                  end else begin
                     rdata_reg  <= `NVBS_ILLEGAL_DATA;
                     idx_reg    <= head_reg - 1'b1;
                     target_reg <= rd_cyc;                       // [RULE19]
                     state_reg  <= S_RSCAN;
                  end
               end
            end
            S_WPROG: begin
               state_reg <= S_WVER;
            end
            S_WVER: begin
               if (fl_entry != new_entry) begin
                  wstat_reg[`NVBS_WR_ERR_BIT] <= 1'b1;           // [RULE14]
               end
               head_reg        <= head_reg + 1'b1;
               since_erase_reg <= since_erase_reg + 16'h0001;
               if (wcnt_reg == `NVBS_MAINT_PERIOD - 8'h01) begin
                  state_reg <= S_MERASE;                         // [RULE12]
               end else begin
                  wcnt_reg  <= wcnt_reg + 8'h01;
                  state_reg <= S_WAIT;
               end
            end
            // Copy the newest good value of each address to the spare
            // page; the old page stays valid until the tag is in place
            S_MERASE: begin
               maddr_reg <= 8'h00;
               dh_reg    <= {{(AW-1){1'b0}}, 1'b1};
               idx_reg   <= head_reg - 1'b1;
               state_reg <= S_MSCAN;
            end
            S_MSCAN: begin
               if (idx_reg == {AW{1'b0}}) begin
                  state_reg <= S_MNEXT;
               end else if (ent_addr == maddr_reg && ent_good) begin
                  copy_reg  <= fl_entry;
                  state_reg <= S_MCOPY;
               end else begin
                  idx_reg <= idx_reg - 1'b1;
               end
            end
            S_MCOPY: begin
               state_reg <= S_MCVER;
            end
            S_MCVER: begin
               if (fl_entry != copy_reg) begin
                  wstat_reg[`NVBS_FLASH_BIT] <= 1'b1;
               end
               dh_reg    <= dh_reg + 1'b1;
               state_reg <= S_MNEXT;
            end
            S_MNEXT: begin
               if (maddr_reg == `NVBS_ARRAY_SIZE - 8'h01) begin
                  state_reg <= S_MTAG;
               end else begin
                  maddr_reg <= maddr_reg + 8'h01;
                  idx_reg   <= head_reg - 1'b1;
                  state_reg <= S_MSCAN;
               end
            end
            S_MTAG: begin
               state_reg <= S_MOLD;
            end
            S_MOLD: begin
               act_reg         <= ~act_reg;
               head_reg        <= dh_reg;
               wcnt_reg        <= 8'h00;
               since_erase_reg <= 16'h0000;
               state_reg       <= S_WAIT;
            end
            // Newest entry first; a bad newest copy is flagged and
            // the scan falls back to older ones
            S_RSCAN: begin
               if (idx_reg == {AW{1'b0}}) begin
                  state_reg <= S_WAIT;
               end else if (ent_addr == addr_reg && ent_good) begin
                  rdata_reg <= ent_data;                         // [RULE17]
                  state_reg <= S_WAIT;
               end else begin
                  if (ent_addr == addr_reg) begin
                     rstat_reg[`NVBS_CORRUPT_BIT] <= 1'b1;
                  end
                  idx_reg <= idx_reg - 1'b1;
               end
            end
            S_WAIT: begin
               if (elapsed_reg >= target_reg) begin              // [RULE23]
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
                  if (is_write_reg) begin
                     first_working_register <= wstat_reg;        // [RULE4]
                  end else begin
                     first_working_register  <= rdata_reg;       // [RULE6]
                     second_working_register <= rstat_reg;
                  end
                  state_reg <= S_IDLE;                           // [RULE8]
               end
            end
            default: begin
               state_reg <= S_INIT0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== verif/nvbs_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "nvbs_regs.vh"

module nvbs_monitor #(
   parameter [25:0] WRITE_CYC    = `NVBS_CYC_DN(`NVBS_WRITE_NS),
   parameter [25:0] ILL_WR_CYC   = `NVBS_CYC_DN(`NVBS_ILL_WRITE_NS),
   parameter [25:0] ILL_RD_CYC   = `NVBS_CYC_DN(`NVBS_ILL_READ_NS),
   parameter [25:0] READ_MIN_CYC = `NVBS_CYC_UP(`NVBS_READ_MIN_NS),
   parameter [25:0] READ_MAX_CYC = `NVBS_CYC_DN(`NVBS_READ_MAX_NS)
) (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       call_write,
   input wire logic       call_read,
   input wire logic [7:0] call_addr,
   input wire logic       busy_reg,
   input wire logic       done_reg,
   input wire logic [7:0] first_working_register,
   input wire logic [7:0] second_working_register
);
   localparam int ILW = ILL_WR_CYC;
   localparam int ILW_HI = ILL_WR_CYC + 3;
   localparam int ILR = ILL_RD_CYC;
   localparam int ILR_HI = ILL_RD_CYC + 3;
   reg [25:0] cnt_reg;
   reg        op_wr_reg;
   reg        legal_reg;
   wire       take = !busy_reg && (call_write || call_read);

   // Cycles since the call was taken, and what kind of call it was
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 26'h0000000;
         op_wr_reg <= 1'b0;
         legal_reg <= 1'b0;
      end else if (take) begin
         cnt_reg <= 26'h0000000;
         op_wr_reg <= call_write;
         legal_reg <= (call_addr < 8'h64);
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg + 26'h0000001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_take_wr;
      !busy_reg && call_write;
   endsequence
   sequence s_take_rd;
      !busy_reg && call_read && !call_write;
   endsequence

   AST_BUSY_AFTER_TAKE: assert property (take |=> busy_reg)
      else $error("busy not raised after a call");
   AST_DONE_PULSE: assert property (done_reg |-> !busy_reg ##1 !done_reg)
      else $error("done not a single pulse with busy low");
   AST_ILL_WRITE: assert property (s_take_wr ##0 (call_addr >= 8'h64) |->
      ##[ILW:ILW_HI] (done_reg && first_working_register == 8'h02))
      else $error("illegal write result or timing wrong");
   AST_ILL_READ: assert property (s_take_rd ##0 (call_addr >= 8'h64) |->
      ##[ILR:ILR_HI] (done_reg && first_working_register == 8'hFF
      && second_working_register == 8'h02))
      else $error("illegal read result or timing wrong");
   AST_WSTAT_ZERO: assert property (done_reg && op_wr_reg
      |-> first_working_register[7:3] == 5'h00)
      else $error("write status upper bits not zero");
   AST_RSTAT_ZERO: assert property (done_reg && !op_wr_reg
      |-> second_working_register[7:5] == 3'h0
      && !second_working_register[3] && !second_working_register[0])
      else $error("read status reserved bits not zero");
   AST_WR_KEEPS_R1: assert property (done_reg && op_wr_reg
      |-> $stable(second_working_register))
      else $error("write changed the second working register");
   AST_WRITE_MIN: assert property (done_reg && op_wr_reg && legal_reg
      |-> cnt_reg >= WRITE_CYC)
      else $error("legal write finished too soon");
   AST_READ_SPAN: assert property (done_reg && !op_wr_reg && legal_reg
      |-> cnt_reg >= READ_MIN_CYC && cnt_reg <= READ_MAX_CYC + 4)
      else $error("legal read time out of range");
endmodule

bind nvbs_top nvbs_monitor #(
   .WRITE_CYC    (WRITE_CYC),
   .ILL_WR_CYC   (ILL_WR_CYC),
   .ILL_RD_CYC   (ILL_RD_CYC),
   .READ_MIN_CYC (READ_MIN_CYC),
   .READ_MAX_CYC (READ_MAX_CYC)
) u_mon (
   .clk                     (clk),
   .rstn                    (rstn),
   .call_write              (call_write),
   .call_read               (call_read),
   .call_addr               (call_addr),
   .busy_reg                (busy_reg),
   .done_reg                (done_reg),
   .first_working_register  (first_working_register),
   .second_working_register (second_working_register)
);
`default_nettype wire

// ==== verif/nvbs_caller.sv ====
`timescale 1ns/10ps
`default_nettype none

// Calling core: one call at a time, address and data given with the call
module nvbs_caller (
   input  wire logic       clk,
   input  wire logic       busy_reg,
   input  wire logic       done_reg,
   output var  logic       call_write,
   output var  logic       call_read,
   output var  logic [7:0] call_addr,
   output var  logic [7:0] call_data
);
   initial begin
      call_write = 1'b0;
      call_read = 1'b0;
      call_addr = 8'h00;
      call_data = 8'h00;
   end

   // Raise a call for one cycle; released address and data lines show the inverse value, call lines go low
   // Arguments ride on the call lines, so no stack room is kept
   task pulse(input logic wr, input logic [7:0] a, input logic [7:0] d);
      call_addr = a;
      call_data = d;
      call_write = wr;
      call_read = !wr;
      @(posedge clk);
      #1;
      call_write = 1'b0;
      call_read = 1'b0;
      call_addr = ~a;
      call_data = ~d;
   endtask

   // Waits for the block to be idle; interrupts are taken as off
   task start(input logic wr, input logic [7:0] a, input logic [7:0] d,
              output bit ok);
      int i;
      ok = 1'b0;
      for (i = 0; i < 50000 && !ok; i++) begin
         @(posedge clk);
         #1;
         ok = (busy_reg === 1'b0);
      end
      if (ok) pulse(wr, a, d);
   endtask

   // Waits for the done pulse, bounded so that a hang is reported
   task finish(output int lat, output bit ok);
      ok = 1'b0;
      for (lat = 1; lat < 50000 && !ok; lat++) begin
         @(posedge clk);
         #1;
         ok = (done_reg === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// ==== verif/nvbs_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module nvbs_top_tb;
   logic       clk;
   logic       rstn;
   logic       brownout_monitor;
   wire        call_write;
   wire        call_read;
   wire  [7:0] call_addr;
   wire  [7:0] call_data;
   wire        busy_reg;
   wire        done_reg;
   wire  [7:0] r0;
   wire  [7:0] r1;
   int         n_mismatch;
   int         compares;
   int         l0;
   int         l1;
   int         i;

   nvbs_top #(.WRITE_CYC(26'h28), .ILL_WR_CYC(26'hA), .ILL_RD_CYC(26'h8),
      .READ_MIN_CYC(26'h14), .READ_MAX_CYC(26'h3C)) dut (
      .clk(clk), .rstn(rstn), .call_write(call_write),
      .call_read(call_read), .call_addr(call_addr), .call_data(call_data),
      .brownout_monitor(brownout_monitor), .busy_reg(busy_reg),
      .done_reg(done_reg), .first_working_register(r0),
      .second_working_register(r1));

   nvbs_caller cpu (.clk(clk), .busy_reg(busy_reg), .done_reg(done_reg),
      .call_write(call_write), .call_read(call_read),
      .call_addr(call_addr), .call_data(call_data));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task tally_and_finish;
      if (n_mismatch == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
         n_mismatch++;
      end
   endtask

   task bounded(input bit ok);
      if (!ok) begin
         $display("CHECK FAILED at %0t: no answer from block", $time);
         n_mismatch++;
         tally_and_finish;
      end
   endtask

   // One call; result checked against the expected status and data
   task op(input logic wr, input logic [7:0] a, input logic [7:0] d,
           input logic [7:0] e0, input logic [7:0] e1, output int lat);
      bit ok;
      cpu.start(wr, a, d, ok);
      bounded(ok);
      wait_done(e0, e1, wr, lat);
   endtask

   task wait_done(input logic [7:0] e0, input logic [7:0] e1,
                  input logic wr, output int lat);
      bit ok;
      cpu.finish(lat, ok);
      bounded(ok);
      chk(r0, e0);
      if (!wr) chk(r1, e1);
   endtask

   task do_reset;
      rstn = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk(r0, 8'h00);
      chk(r1, 8'h00);
      rstn = 1'b1;
   endtask

   initial begin
      rstn = 1'b0;
      brownout_monitor = 1'b1;
      n_mismatch = 0;
      compares = 0;
      do_reset;
      op(0, 8'h05, 8'h00, 8'hFF, 8'h00, l0);
      op(1, 8'h00, 8'hA5, 8'h00, 8'h00, l1);
      op(0, 8'h00, 8'h00, 8'hA5, 8'h00, l1);
      op(1, 8'h63, 8'h3C, 8'h00, 8'h00, l1);
      op(1, 8'h64, 8'h11, 8'h02, 8'h00, l1);
      op(0, 8'h64, 8'h00, 8'hFF, 8'h02, l1);
      op(0, 8'hFF, 8'h00, 8'hFF, 8'h02, l1);
      op(1, 8'h00, 8'h5A, 8'h00, 8'h00, l1);
      op(0, 8'h00, 8'h00, 8'h5A, 8'h00, l1);
      op(0, 8'h63, 8'h00, 8'h3C, 8'h00, l1);
      brownout_monitor = 1'b0;
      op(1, 8'h01, 8'h77, 8'h04, 8'h00, l1);
      brownout_monitor = 1'b1;
      op(0, 8'h01, 8'h00, 8'hFF, 8'h00, l1);
      op(0, 8'h32, 8'h00, 8'hFF, 8'h00, l1);
      chk(8'(l1 > l0), 8'h01);
      // A call made while busy must be dropped
      cpu.start(1, 8'h02, 8'hD4, l0[0]);
      @(posedge clk);
      #1;
      cpu.pulse(1, 8'h03, 8'hE1);
      wait_done(8'h00, 8'h00, 1, l1);
      op(0, 8'h03, 8'h00, 8'hFF, 8'h00, l1);
      op(0, 8'h02, 8'h00, 8'hD4, 8'h00, l1);
      // Enough writes to pass a maintenance erase
      for (i = 0; i < 200; i++)
         op(1, 8'(8'h10 + i % 10), 8'(i), 8'h00, 8'h00, l1);
      for (i = 0; i < 10; i++)
         op(0, 8'(8'h10 + i), 0, 8'(190 + i), 8'h00, l1);
      op(0, 8'h00, 8'h00, 8'h5A, 8'h00, l1);
      // Reset in the middle of a write
      cpu.start(1, 8'h04, 8'h99, l0[0]);
      repeat (10) @(posedge clk);
      #1;
      do_reset;
      op(0, 8'h00, 8'h00, 8'h5A, 8'h00, l1);
      op(0, 8'h63, 8'h00, 8'h3C, 8'h00, l1);
      op(0, 8'h15, 8'h00, 8'hC3, 8'h00, l1);
      tally_and_finish;
   end
endmodule
`default_nettype wire
